// file: shared/edrm_pkg.sv
package edrm_pkg;
    // Initialization block byte offsets of the two ring pointer words
    localparam logic [23:0] INIT_RX_PTR_OFS = 24'h000010;
    localparam logic [23:0] INIT_TX_PTR_OFS = 24'h000014;
    // Descriptor geometry and word offsets
    localparam int DESC_SHIFT = 3;
    localparam logic [2:0] DESC_ADDR_OFS = 3'h0;
    localparam logic [2:0] DESC_STAT_OFS = 3'h2;
    localparam logic [2:0] DESC_SIZE_OFS = 3'h4;
    localparam logic [2:0] DESC_LEN_OFS = 3'h6;
    // Status word bit positions, size field ones and buffer/packet byte limits
    localparam int OWN_BIT = 15;
    localparam int FAULT_BIT = 14;
    localparam int ALIGN_BIT = 13;
    localparam int OVERRUN_BIT = 12;
    localparam int CRC_BIT = 11;
    localparam int SHORTAGE_BIT = 10;
    localparam int FIRST_BIT = 9;
    localparam int LAST_BIT = 8;
    localparam logic [3:0] SIZE_ONES = 4'hF;
    localparam logic [11:0] MIN_BUF_BYTES = 12'h040;
    localparam logic [11:0] MAX_PKT_BYTES = 12'h5EE;
    // Buffers are placed at a fixed 2 KiB stride from the pool base
    localparam int BUF_SHIFT = 11;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_INIT = 3'b001,
        ST_RXD = 3'b010,
        ST_TXD = 3'b011,
        ST_POLL = 3'b100,
        ST_LEN = 3'b101,
        ST_PUSH = 3'b110,
        ST_RECLAIM = 3'b111
    } edrm_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [23:0] addr;
        logic [15:0] wdata;
    } edrm_mem_req_s;

    typedef struct packed {
        logic [23:0] buf_addr;
        logic [11:0] length;
        logic length_valid;
        logic first;
        logic last;
        logic fault;
        logic align;
        logic overrun;
        logic crc;
        logic shortage;
    } edrm_rx_info_s;
endpackage

// file: design/edrm_host.sv
// How it works
// [R1] Receive ring entries are two to the power of the top-three-bit size code.
// [R2] Receive ring base sits in low 24 bits, three low bits forced zero.
// [R3] The five bits between size code and base are written as zeros.
// [R4] Transmit ring size code uses the same power-of-two encoding.
// [R5] Transmit ring base sits in low 24 bits, quadword aligned.
// [R6] Receive pointer goes to init bytes 16-19, transmit pointer to 20-23.
// [R7] Descriptors are contiguous 8-byte entries; index wraps modulo ring size.
// [R8] The device only looks one descriptor ahead of its current one.
// [R9] Every buffer is at least 64 bytes long.
// [R10] Ownership is only handed over; a handed-over descriptor is left alone.
// [R11] Before start, receive descriptors are device-owned, transmit ones host-owned.
// [R12] Buffer address: low 16 bits at offset 0, high 8 bits at offset 2.
// [R13] Possession bit 15 is the last thing written when handing over.
// [R14] Summary fault bit 14 is OR of the four error bits.
// [R15] Bit 13 flags a non-byte-length packet with bad CRC.
// [R16] Bit 12 flags packet data lost to internal overflow.
// [R17] Bit 11 flags an invalid CRC.
// [R18] Bit 10 flags running out of descriptors; overflow then also set.
// [R19] Bits 9 and 8 mark first and last buffer of a packet.
// [R20] Offset 4 holds four ones and the negated buffer size.
// [R21] Offset 6 top bits zero; length valid only with last set, fault clear.
// [R22] Device advances its index only after clearing possession.
`timescale 1ns/1ps
`default_nettype none
module edrm_host (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [23:0] init_block_base_i,
    input wire logic [23:0] rx_ring_base_i,
    input wire logic [2:0] rx_ring_size_code_i,
    input wire logic [23:0] tx_ring_base_i,
    input wire logic [2:0] tx_ring_size_code_i,
    input wire logic [23:0] buf_pool_base_i,
    input wire logic [11:0] buf_size_i,
    output logic running_o,
    output var edrm_pkg::edrm_mem_req_s mem_req_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output var edrm_pkg::edrm_rx_info_s rx_data_o
);
    import edrm_pkg::*;

    typedef struct packed {
        edrm_state_e st;
        logic [1:0] step;
        logic [6:0] idx;
        logic [23:0] init_base;
        logic [23:0] rx_base;
        logic [2:0] rx_code;
        logic [23:0] tx_base;
        logic [2:0] tx_code;
        logic [23:0] pool;
        logic [11:0] size;
        logic [15:0] stat;
        logic [11:0] len;
        edrm_mem_req_s req;
        edrm_rx_info_s [1:0] fifo;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } edrm_host_s;

    edrm_host_s s, n;
    logic [6:0] rx_mask, tx_mask, mask;
    logic [31:0] rx_ptr, tx_ptr;
    logic [63:0] ptrs;
    logic [23:0] buf_addr, ring_base, desc;
    logic [11:0] neg_size;
    logic wr, last_step, finish, active, push, pop;
    logic [23:0] addr;
    logic [15:0] data;
    edrm_rx_info_s info;

    assign rx_mask = 7'((8'h01 << s.rx_code) - 8'h01); // R1
    assign tx_mask = 7'((8'h01 << s.tx_code) - 8'h01); // R4
    assign mask = (s.st == ST_TXD) ? tx_mask : rx_mask;
    assign rx_ptr = {s.rx_code, 5'h00, s.rx_base[23:3], 3'h0}; // R2 R3
    assign tx_ptr = {s.tx_code, 5'h00, s.tx_base[23:3], 3'h0}; // R5 R3
    assign ptrs = {tx_ptr, rx_ptr};
    assign ring_base = (s.st == ST_TXD) ? s.tx_base : s.rx_base;
    assign desc = ring_base + (24'(s.idx) << DESC_SHIFT); // R7
    assign buf_addr = s.pool + (24'(s.idx) << BUF_SHIFT);
    assign neg_size = 12'h000 - ((s.size < MIN_BUF_BYTES) ? MIN_BUF_BYTES : s.size); // R9 R20
    assign active = (s.st != ST_IDLE) && (s.st != ST_PUSH);
    assign pop = (s.cnt != 2'h0) && rx_ready_i;
    assign push = (s.st == ST_PUSH) && (s.cnt != FIFO_DEPTH);

    always_comb begin
        info = '0;
        info.buf_addr = buf_addr;
        info.first = s.stat[FIRST_BIT]; // R19
        info.last = s.stat[LAST_BIT]; // R19
        info.fault = s.stat[FAULT_BIT]; // R14
        info.align = s.stat[ALIGN_BIT]; // R15
        info.overrun = s.stat[OVERRUN_BIT]; // R16
        info.crc = s.stat[CRC_BIT]; // R17
        info.shortage = s.stat[SHORTAGE_BIT]; // R18
        info.length = s.len;
        info.length_valid = s.stat[LAST_BIT] && !s.stat[FAULT_BIT]; // R21
    end

    always_comb begin
        wr = 1'b1;
        addr = desc;
        data = 16'h0000;
        last_step = 1'b1;
        unique case (s.st)
            ST_INIT: begin
                addr = s.init_base + INIT_RX_PTR_OFS + 24'({s.step, 1'b0}); // R6
                data = ptrs[{s.step, 4'h0} +: 16];
                last_step = (s.step == 2'h3);
            end
            ST_RXD: begin
                last_step = (s.step == 2'h3);
                unique case (s.step)
                    2'h0: data = buf_addr[15:0]; // R12
                    2'h1: begin
                        addr = desc + 24'(DESC_SIZE_OFS);
                        data = {SIZE_ONES, neg_size}; // R20
                    end
                    2'h2: addr = desc + 24'(DESC_LEN_OFS); // R21
                    2'h3: begin
                        addr = desc + 24'(DESC_STAT_OFS);
                        data = {1'b1, 7'h00, buf_addr[23:16]}; // R11 R12 R13
                    end
                endcase
            end
            ST_TXD: addr = desc + 24'(DESC_STAT_OFS); // R11
            ST_POLL: begin
                wr = 1'b0;
                addr = desc + 24'(DESC_STAT_OFS); // R8
            end
            ST_LEN: begin
                wr = 1'b0;
                addr = desc + 24'(DESC_LEN_OFS);
            end
            ST_RECLAIM: begin
                last_step = s.step[0];
                if (!s.step[0]) begin
                    addr = desc + 24'(DESC_LEN_OFS); // R21
                end else begin
                    addr = desc + 24'(DESC_STAT_OFS);
                    data = {1'b1, 7'h00, buf_addr[23:16]}; // R13 R10
                end
            end
            default: begin
                wr = 1'b0;
            end
        endcase
    end

    always_comb begin
        n = s;
        finish = 1'b0;
        if (active) begin
            if (!s.req.valid) begin
                n.req = '{1'b1, wr, addr, data};
            end else if (mem_ack_i) begin
                n.req.valid = 1'b0;
                n.step = s.step + 2'h1;
                finish = last_step;
            end
        end
        if (pop) begin
            n.rp = ~s.rp;
        end
        if (push) begin
            n.fifo[s.wp] = info;
            n.wp = ~s.wp;
        end
        n.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
        if (finish) begin
            n.step = 2'h0;
        end
        unique case (s.st)
            ST_IDLE: begin
                if (start_i) begin
                    n.st = ST_INIT;
                    n.step = 2'h0;
                    n.idx = 7'h00;
                    n.init_base = init_block_base_i;
                    n.rx_base = {rx_ring_base_i[23:3], 3'h0}; // R2
                    n.rx_code = rx_ring_size_code_i;
                    n.tx_base = {tx_ring_base_i[23:3], 3'h0}; // R5
                    n.tx_code = tx_ring_size_code_i;
                    n.pool = buf_pool_base_i;
                    n.size = buf_size_i;
                end
            end
            ST_INIT: begin
                if (finish) begin
                    n.st = ST_RXD;
                end
            end
            ST_RXD, ST_TXD: begin
                if (finish) begin
                    n.idx = (s.idx + 7'h01) & mask; // R7
                    if (s.idx == mask) begin
                        n.st = (s.st == ST_RXD) ? ST_TXD : ST_POLL;
                    end
                end
            end
            ST_POLL: begin
                if (finish) begin
                    n.stat = mem_rdata_i;
                    n.len = 12'h000;
                    if (!mem_rdata_i[OWN_BIT]) begin // R10
                        n.st = mem_rdata_i[LAST_BIT] ? ST_LEN : ST_PUSH; // R21
                    end
                end
            end
            ST_LEN: begin
                if (finish) begin
                    n.len = mem_rdata_i[11:0]; // R21
                    n.st = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (push) begin
                    n.st = ST_RECLAIM;
                end
            end
            ST_RECLAIM: begin
                if (finish) begin
                    n.idx = (s.idx + 7'h01) & rx_mask; // R7 R22
                    n.st = ST_POLL;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign mem_req_o = s.req;
    assign rx_valid_o = (s.cnt != 2'h0);
    assign rx_data_o = s.fifo[s.rp];
    assign running_o = s.st[2];

    rsvd_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
        s.req.valid && s.st == ST_INIT && s.step[0] |-> s.req.wdata[12:8] == 5'h00)
        else $error("reserved ring pointer bits not zero");
    quad_align_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
        s.req.valid && s.st == ST_INIT && !s.step[0] |-> s.req.wdata[2:0] == 3'h0)
        else $error("ring base not quadword aligned");
    size_field_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R20
        s.req.valid && s.st == ST_RXD && s.step == 2'h1 |->
        s.req.wdata[15:12] == SIZE_ONES && (12'h000 - s.req.wdata[11:0]) >= MIN_BUF_BYTES)
        else $error("bad buffer size word");
    own_last_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
        s.req.valid && s.st == ST_RXD && s.req.addr[2:0] == DESC_STAT_OFS |->
        s.req.wdata[OWN_BIT] && s.step == 2'h3)
        else $error("possession not handed over last");
    tx_host_own_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
        s.req.valid && s.st == ST_TXD |-> !s.req.wdata[OWN_BIT] && s.req.write)
        else $error("transmit descriptor not host owned");
    no_seize_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
        s.st == ST_POLL && s.req.valid |-> !s.req.write)
        else $error("write while descriptor device owned");
    idx_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
        s.st == ST_RECLAIM && s.step[0] && s.req.valid && mem_ack_i |=>
        s.idx == (($past(s.idx) + 7'h01) & rx_mask) && s.st == ST_POLL)
        else $error("ring index did not wrap");
    advance_late_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R22
        running_o && $past(running_o) && s.idx != $past(s.idx) |->
        $past(s.st == ST_RECLAIM && mem_ack_i))
        else $error("index advanced before handover");
    len_valid_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R21
        rx_valid_o && rx_data_o.length_valid |-> rx_data_o.last && !rx_data_o.fault)
        else $error("length reported as valid without last");
    stall_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
        else $error("output word lost under stall");
    req_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s.req.valid && !mem_ack_i |=> s.req.valid && $stable(s.req))
        else $error("memory request dropped");
    len_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R21
        s.req.valid && s.st == ST_RECLAIM && !s.step[0] |->
        s.req.write && s.req.addr[2:0] == DESC_LEN_OFS && s.req.wdata == 16'h0000)
        else $error("length word not cleared on reclaim");
    reclaim_own_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
        s.req.valid && s.st == ST_RECLAIM && s.step[0] |->
        s.req.write && s.req.addr[2:0] == DESC_STAT_OFS && s.req.wdata[OWN_BIT])
        else $error("possession not returned on reclaim");
    desc_align_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2 R5
        s.req.valid && s.st != ST_INIT |-> s.req.addr[0] == 1'b0 && desc[2:0] == 3'h0)
        else $error("descriptor access not aligned");
    own_release_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
        s.st == ST_PUSH |-> !s.stat[OWN_BIT])
        else $error("pushed a descriptor still owned by the device");
    fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s.cnt <= FIFO_DEPTH)
        else $error("output buffer count out of range");
endmodule
`default_nettype wire

// file: testbench/edrm_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module edrm_dev_model #(
    parameter logic [23:0] INIT_BASE = 24'h000100
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] ack_delay_i,
    input wire edrm_pkg::edrm_mem_req_s mem_req_i,
    output logic mem_ack_o,
    output logic [15:0] mem_rdata_o
);
    import edrm_pkg::*;
    logic [15:0] mem [0:8191];
    logic [3:0] wait_cnt;

    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 16'hDEAD;
        end
    end

    // Read data toggles on every cycle that does not answer a read so stale values never look valid
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            mem_rdata_o <= 16'h5A5A;
        end else begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_req_i.valid && !mem_ack_o) begin
                if (wait_cnt < ack_delay_i) begin
                    wait_cnt <= wait_cnt + 4'h1;
                end else begin
                    wait_cnt <= 4'h0;
                    mem_ack_o <= 1'b1;
                    if (mem_req_i.write) begin
                        mem[mem_req_i.addr[13:1]] <= mem_req_i.wdata;
                    end else begin
                        mem_rdata_o <= mem[mem_req_i.addr[13:1]];
                    end
                end
            end
        end
    end

    // Device fills a receive descriptor; flags are align,overrun,crc,shortage,first,last
    task automatic deliver(input int idx, input logic [5:0] fl, input logic [11:0] len);
        logic [15:0] lo;
        logic [15:0] hi;
        logic [23:0] d;
        logic [5:0] f;
        lo = mem[INIT_BASE[13:1] + 13'h8];
        hi = mem[INIT_BASE[13:1] + 13'h9];
        d = {hi[7:0], lo[15:3], 3'b000} + 24'((idx % (1 << hi[15:13])) * 8);
        f = fl | {1'b0, fl[2], 4'h0};
        mem[d[13:1] + 13'h3] = {4'h0, len};
        mem[d[13:1] + 13'h1] = {1'b0, |f[5:2], f, mem[d[13:1] + 13'h1][7:0]};
    endtask
endmodule
`default_nettype wire

// file: testbench/edrm_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module edrm_host_tb;
    import edrm_pkg::*;
    localparam logic [23:0] INIT = 24'h000100;
    logic clk, rst_n, start, ready, ack, running, rxv;
    logic [3:0] dly;
    logic [23:0] init_base, rx_base, tx_base, pool, d, b;
    logic [2:0] rx_code, tx_code;
    logic [11:0] bsize;
    logic [15:0] rdata;
    edrm_mem_req_s req;
    edrm_rx_info_s rxd;
    int fails = 0;
    int num_checks = 0;
    int n;

    edrm_host i_edrm_host (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .init_block_base_i(init_base),
        .rx_ring_base_i(rx_base), .rx_ring_size_code_i(rx_code), .tx_ring_base_i(tx_base),
        .tx_ring_size_code_i(tx_code), .buf_pool_base_i(pool), .buf_size_i(bsize), .running_o(running),
        .mem_req_o(req), .mem_ack_i(ack), .mem_rdata_i(rdata), .rx_valid_o(rxv), .rx_ready_i(ready),
        .rx_data_o(rxd));
    edrm_dev_model #(.INIT_BASE(INIT)) i_edrm_dev_model (.clk_i(clk), .rst_n_i(rst_n), .ack_delay_i(dly),
        .mem_req_i(req), .mem_ack_o(ack), .mem_rdata_o(rdata));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [15:0] rd(input logic [23:0] a);
        return i_edrm_dev_model.mem[a[13:1]];
    endfunction

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    task automatic close_out;
        $display("fails=%0d num_checks=%0d", fails, num_checks);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Flags: length_valid, fault, align, overrun, crc, shortage, first, last
    task automatic pop(input logic [23:0] ba, input logic [11:0] len, input logic [7:0] fl);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (rxv !== 1'b1 && k < 2000);
        chk("rx_valid", 24'h1, 24'(rxv));
        chk("rx_buf_addr", ba, rxd.buf_addr);
        chk("rx_length", 24'(len), 24'(rxd.length));
        chk("rx_flags", 24'(fl), 24'({rxd.length_valid, rxd.fault, rxd.align, rxd.overrun, rxd.crc,
            rxd.shortage, rxd.first, rxd.last}));
        @(posedge clk);
        ready <= 1'b1;
        @(posedge clk);
        ready <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        ready = 1'b0;
        dly = 4'h3;
        init_base = INIT;
        rx_base = 24'h000205;
        rx_code = 3'h2;
        tx_base = 24'h000300;
        tx_code = 3'h1;
        pool = 24'h3A1000;
        bsize = 12'h020;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        while (running !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("running", 24'h1, 24'(running));
        chk("rx_ptr_lo", 24'h000200, 24'(rd(INIT + 24'h10)));
        chk("rx_ptr_hi", 24'h004000, 24'(rd(INIT + 24'h12)));
        chk("tx_ptr_lo", 24'h000300, 24'(rd(INIT + 24'h14)));
        chk("tx_ptr_hi", 24'h002000, 24'(rd(INIT + 24'h16)));
        for (int k = 0; k < 4; k++) begin
            d = 24'h000200 + 24'(8 * k);
            b = 24'h3A1000 + 24'(k * 2048);
            chk("desc_addr_lo", 24'(b[15:0]), 24'(rd(d)));
            chk("desc_size", 24'h00FFC0, 24'(rd(d + 24'h4)));
            chk("desc_len", 24'h0, 24'(rd(d + 24'h6)));
            chk("desc_status", 24'h8000 | 24'(b[23:16]), 24'(rd(d + 24'h2)));
        end
        for (int k = 0; k < 2; k++) begin
            chk("tx_desc_status", 24'h0, 24'(rd(24'h000302 + 24'(8 * k))));
        end
        dly <= 4'h0;
        @(negedge clk);
        i_edrm_dev_model.deliver(0, 6'b000011, 12'd100);
        i_edrm_dev_model.deliver(1, 6'b000010, 12'h7FF);
        i_edrm_dev_model.deliver(2, 6'b001001, 12'd60);
        i_edrm_dev_model.deliver(3, 6'b000101, 12'd5);
        repeat (300) @(posedge clk);
        chk("stalled_desc", 24'h00493A, 24'(rd(24'h000212)));
        chk("reclaimed_early", 24'h00803A, 24'(rd(24'h000202)));
        pop(24'h3A1000, 12'd100, 8'b1000_0011);
        pop(24'h3A1800, 12'd0, 8'b0000_0010);
        pop(24'h3A2000, 12'd60, 8'b0100_1001);
        pop(24'h3A2800, 12'd5, 8'b0101_0101);
        repeat (100) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            d = 24'h000200 + 24'(8 * k);
            chk("reclaim_status", 24'h00803A, 24'(rd(d + 24'h2)));
            chk("reclaim_len", 24'h0, 24'(rd(d + 24'h6)));
            chk("reclaim_size", 24'h00FFC0, 24'(rd(d + 24'h4)));
        end
        @(negedge clk);
        i_edrm_dev_model.deliver(4, 6'b101001, 12'd7);
        pop(24'h3A1000, 12'd7, 8'b0110_1001);
        repeat (100) @(posedge clk);
        @(negedge clk);
        chk("rx_valid_idle", 24'h0, 24'(rxv));
        // Mid-run reset, then a one-entry ring with an unclamped buffer size
        @(posedge clk);
        rst_n <= 1'b0;
        rx_code <= 3'h0;
        bsize <= 12'h600;
        dly <= 4'h1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        while (running !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("running_again", 24'h1, 24'(running));
        chk("rx_ptr_hi_one", 24'h0, 24'(rd(INIT + 24'h12)));
        chk("desc_size_big", 24'h00FA00, 24'(rd(24'h000204)));
        @(negedge clk);
        i_edrm_dev_model.deliver(9, 6'b000011, 12'd1500);
        pop(24'h3A1000, 12'd1500, 8'b1000_0011);
        repeat (50) @(posedge clk);
        chk("wrap_status", 24'h00803A, 24'(rd(24'h000202)));
        close_out();
    end
endmodule
`default_nettype wire
